// ===== logic/vic_top.sv
// Purpose: Vectored interrupt controller with AXI4-Lite registers.
// Assumes: One clock; the core pulses intr_ack_cycle and intr_return.
// Notes: Writes complete two edges after both channels are offered.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.

`default_nettype none

module vic_top
	import vic_pkg::*;
#(
	parameter int AXI_AW = 8
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Request sources
	input wire logic nmi_in,
	input wire logic ext_irq_one,
	input wire logic pstack_underflow_irq,
	input wire logic rstack_underflow_irq,
	input wire logic pstack_pointer_wr,
	input wire logic rstack_pointer_wr,
	// Core side
	output logic core_intr_req,
	input wire logic intr_ack_cycle,
	input wire logic intr_return,
	output logic [15:0] ext_bus_vector,
	output logic ext_bus_vector_valid,
	// Interrupt to the system
	output logic irq
);

	// The decoder reads the low eight address bits, so fewer cannot work.
	generate
		if (AXI_AW < 8 || AXI_AW > 32)
		begin : g_bad_aw
			$error("AXI_AW must lie between 8 and 32");
		end
	endgenerate

	vic_src_if src ();

	vic_source_cond u_cond (
		.aclk(aclk),
		.aresetn(aresetn),
		.nmi_in(nmi_in),
		.ext_irq_one(ext_irq_one),
		.pstack_underflow_irq(pstack_underflow_irq),
		.rstack_underflow_irq(rstack_underflow_irq),
		.pstack_pointer_wr(pstack_pointer_wr),
		.rstack_pointer_wr(rstack_pointer_wr),
		.src(src.cond)
	);

	vic_prio_enc u_enc (
		.src(src.enc)
	);

	// Register state.
	logic [15:0] config_r;
	logic [15:0] config_nxt;
	logic dis_flag_r;
	logic dis_flag_nxt;
	logic [15:0] mask_r;
	logic [15:0] mask_nxt;
	logic [15:0] vector_r;
	logic vec_valid_r;
	logic [NEVT-1:0] evt_stat_r;
	logic [NEVT-1:0] evt_stat_nxt;
	logic [NEVT-1:0] evt_mask_r;
	logic [NEVT-1:0] evt_mask_nxt;
	logic [NSRC-1:0] pending_d_r;

	// Write channel state.
	logic aw_hold_r;
	logic w_hold_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;

	// Read channel state.
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	// Bus decode.
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire wr_go = aw_hold_r & w_hold_r;
	wire [15:0] be16 = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	wire [15:0] wd16 = wdata_r[15:0];
	wire wr_cfg = wr_go & (awaddr_r == OFF_CONFIG);
	wire wr_mask = wr_go & (awaddr_r == OFF_MASK);
	wire wr_estat = wr_go & (awaddr_r == OFF_EVT_STAT);
	wire wr_emask = wr_go & (awaddr_r == OFF_EVT_MASK);
	wire wr_ro = wr_go & ((awaddr_r == OFF_STATUS) |
		(awaddr_r == OFF_VECTOR));
	wire wr_hit = wr_cfg | wr_mask | wr_estat | wr_emask | wr_ro;
	wire [7:0] ar_off = s_axi_araddr[7:0];

	// Core handshake decode.
	wire ack_hit = intr_ack_cycle & src.hit;
	wire [15:0] vec_addr = {10'h000, src.vec_code, 1'b0}; // RULE6
	wire [NSRC-1:0] new_pend = src.pending & ~pending_d_r;
	wire [NEVT-1:0] evt_set = {ack_hit, new_pend};

	// Mask bit n belongs to priority n; the edge source has no mask bit.
	assign src.enable = {~mask_r[NSRC-1:1], 1'b1}; // RULE2
	assign src.nmi_clr = ack_hit & (src.vec_code == VEC_TOP); // RULE14

	// The request follows live pending state, so a level that is still
	// high when the handler returns raises the core again at once.
	assign core_intr_req = src.hit & ~dis_flag_r; // RULE2 RULE8 RULE9

	// Read data for the address offered on the read channel.
	logic [31:0] rd_word;
	logic rd_ok;

	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		case (ar_off)
			OFF_CONFIG:
			begin
				rd_word[15:0] = config_r;
				rd_word[CFG_DIS_BIT] = 1'b0; // RULE11
			end
			OFF_MASK:
			begin
				rd_word[NSRC-1:1] = mask_r[NSRC-1:1];
			end
			OFF_STATUS:
			begin
				rd_word[NSRC-1:0] = src.pending;
				rd_word[STAT_DIS_BIT] = dis_flag_r; // RULE12
				rd_word[STAT_REQ_BIT] = core_intr_req;
			end
			OFF_VECTOR:
			begin
				rd_word[15:0] = vector_r;
			end
			OFF_EVT_STAT:
			begin
				rd_word[NEVT-1:0] = evt_stat_r;
			end
			OFF_EVT_MASK:
			begin
				rd_word[NEVT-1:0] = evt_mask_r;
			end
			default:
			begin
				rd_ok = 1'b0;
			end
		endcase
	end

	// Next values of the software registers.
	always_comb
	begin
		config_nxt = config_r;
		mask_nxt = mask_r;
		evt_mask_nxt = evt_mask_r;
		evt_stat_nxt = evt_stat_r;
		dis_flag_nxt = dis_flag_r;
		if (wr_cfg)
		begin
			config_nxt = (config_r & ~be16) | (wd16 & be16);
		end
		if (wr_mask)
		begin
			mask_nxt = (mask_r & ~be16) | (wd16 & be16);
		end
		if (wr_emask && wstrb_r[0])
		begin
			evt_mask_nxt = wdata_r[NEVT-1:0];
		end
		if (wr_estat && wstrb_r[0])
		begin
			evt_stat_nxt = evt_stat_r & ~wdata_r[NEVT-1:0];
		end
		// Events arriving with a clear still land.
		evt_stat_nxt = evt_stat_nxt | evt_set;
		// The handler return re-enables; a register write overrides that;
		// an acknowledge in the same cycle wins over both so the vector
		// just taken cannot be chased by a second request.
		if (intr_return)
		begin
			dis_flag_nxt = 1'b0; // RULE7
		end
		if (wr_cfg && wstrb_r[0])
		begin
			dis_flag_nxt = wdata_r[CFG_DIS_BIT]; // RULE9 RULE11
		end
		if (ack_hit)
		begin
			dis_flag_nxt = 1'b1; // RULE3
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			config_r <= CFG_RESET;
			dis_flag_r <= 1'b1; // RULE10
			mask_r <= MASK_RESET;
			evt_stat_r <= '0;
			evt_mask_r <= EVT_MASK_RESET;
			pending_d_r <= '0;
		end
		else
		begin
			config_r <= config_nxt;
			dis_flag_r <= dis_flag_nxt;
			mask_r <= mask_nxt;
			evt_stat_r <= evt_stat_nxt;
			evt_mask_r <= evt_mask_nxt;
			pending_d_r <= src.pending;
		end
	end

	// Vector onto the extension bus in the cycle after the acknowledge cycle.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			vector_r <= 16'h0000;
			vec_valid_r <= 1'b0;
		end
		else
		begin
			vec_valid_r <= ack_hit; // RULE4
			if (ack_hit)
			begin
				vector_r <= vec_addr; // RULE4
			end
		end
	end

	assign ext_bus_vector = vector_r;
	assign ext_bus_vector_valid = vec_valid_r;
	assign irq = |(evt_stat_r & evt_mask_r);

	// Write channels: address and data are held separately, so they may
	// arrive in either order; the response waits for both.
	assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
	assign s_axi_wready = ~w_hold_r & ~bvalid_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end
		else
		begin
			if (aw_take)
			begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr[7:0];
			end
			if (w_take)
			begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_r && s_axi_bready)
			begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// Read channel: one read at a time, answered on the next edge.
	assign s_axi_arready = ~rvalid_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_word;
			rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_r && s_axi_rready)
		begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

endmodule

`default_nettype wire

// ===== logic/vic_pkg.sv
// Purpose: Shared constants for the vectored interrupt controller.
// Assumes: 32-bit AXI4-Lite register access, one clock, synchronous reset.
// Notes: Source index equals priority number; index 0 is the highest.
// Behaviour
// [RULE1] Accept stack-controller, timer/counter and external-pin interrupt requests; the code has no timer/counter source.
// [RULE2] Raise the core request only for pending sources not masked in the mask register.
// [RULE3] With interrupts enabled the core runs an acknowledge cycle, disabling interrupts.
// [RULE4] During acknowledge, drive the vector of the highest-priority pending unmasked source; the code drives it in the following cycle.
// [RULE5] Order: edge NMI 01111, input one 01110, pstack 01101, rstack 01100.
// [RULE6] The core calls the page-zero address held in the vector.
// [RULE7] The core marks interrupt calls and re-enables interrupts on the matching return.
// [RULE8] A still-active cause raises the request again right after the return.
// [RULE9] Clearing the disable flag enables interrupts; setting it disables them.
// [RULE10] Reset sets the disable flag, configuration bit 4, to one.
// [RULE11] The disable bit is write-only, reads zero; read then write-back enables.
// [RULE12] The true disable flag reads at bit 14 of the status register.
// [RULE13] A stack error stays asserted until its stack pointer is rewritten.
// [RULE14] The edge request is latched until acknowledged; level requests follow their source.

`default_nettype none

package vic_pkg;

	localparam int NSRC = 4;
	localparam int SRC_NMI = 0;
	localparam int SRC_EXT1 = 1;
	localparam int SRC_PSTACK = 2;
	localparam int SRC_RSTACK = 3;

	// Vector code of priority 0; each lower priority is one less.
	localparam logic [4:0] VEC_TOP = 5'h0f;

	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_MASK = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_VECTOR = 8'h0c;
	localparam logic [7:0] OFF_EVT_STAT = 8'h10;
	localparam logic [7:0] OFF_EVT_MASK = 8'h14;

	localparam int CFG_DIS_BIT = 4;
	localparam int STAT_DIS_BIT = 14;
	localparam int STAT_REQ_BIT = 15;
	localparam int EVT_ACK_BIT = 4;
	localparam int NEVT = 5;

	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] MASK_RESET = 16'hffff;
	localparam logic [NEVT-1:0] EVT_MASK_RESET = 5'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// ===== logic/vic_src_if.sv
// Purpose: Carries source state between the conditioning, encoder and top.
// Assumes: One clock domain.
// Notes: Enable bits 3 to 1 are the inverse of the mask register and bit 0 is held high, supplied by the top.

`default_nettype none

interface vic_src_if;
	import vic_pkg::*;

	logic [NSRC-1:0] pending;
	logic [NSRC-1:0] enable;
	logic nmi_clr;
	logic hit;
	logic [4:0] vec_code;

	modport cond (output pending, input nmi_clr);
	modport enc (input pending, input enable, output hit, output vec_code);
	modport top (input pending, output enable, output nmi_clr,
		input hit, input vec_code);
endinterface

`default_nettype wire

// ===== logic/vic_source_cond.sv
// Purpose: Turns raw request inputs into pending flags.
// Assumes: Inputs are synchronous to aclk.
// Notes: Stack error inputs are one-cycle error pulses from the stack units.

`default_nettype none

module vic_source_cond
	import vic_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Request sources
	input wire logic nmi_in,
	input wire logic ext_irq_one,
	input wire logic pstack_underflow_irq,
	input wire logic rstack_underflow_irq,
	input wire logic pstack_pointer_wr,
	input wire logic rstack_pointer_wr,
	// Pending flags
	vic_src_if.cond src
);

	logic nmi_d_r;
	logic nmi_lat_r;
	logic pstack_err_r;
	logic rstack_err_r;
	logic nmi_rise;

	assign nmi_rise = nmi_in & ~nmi_d_r;

	// A new edge in the acknowledge cycle wins over the clear.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			nmi_d_r <= 1'b0;
			nmi_lat_r <= 1'b0;
			pstack_err_r <= 1'b0;
			rstack_err_r <= 1'b0;
		end
		else
		begin
			nmi_d_r <= nmi_in;
			nmi_lat_r <= nmi_rise | (nmi_lat_r & ~src.nmi_clr); // RULE14
			pstack_err_r <= pstack_underflow_irq |
				(pstack_err_r & ~pstack_pointer_wr); // RULE13
			rstack_err_r <= rstack_underflow_irq |
				(rstack_err_r & ~rstack_pointer_wr); // RULE13
		end
	end

	assign src.pending[SRC_NMI] = nmi_lat_r; // RULE14
	assign src.pending[SRC_EXT1] = ext_irq_one; // RULE14
	assign src.pending[SRC_PSTACK] = pstack_err_r; // RULE1
	assign src.pending[SRC_RSTACK] = rstack_err_r; // RULE1

endmodule

`default_nettype wire

// ===== logic/vic_prio_enc.sv
// Purpose: Picks the highest-priority pending enabled source and its vector.
// Assumes: Index 0 is the highest priority.
// Notes: Purely combinational.

`default_nettype none

module vic_prio_enc
	import vic_pkg::*;
(
	// Source state
	vic_src_if.enc src
);

	logic [NSRC-1:0] act;
	logic [NSRC:0] above;
	logic [NSRC-1:0] win;
	logic [4:0] sel;

	assign act = src.pending & src.enable; // RULE2
	assign above[0] = 1'b0;

	genvar i;
	generate
		for (i = 0; i < NSRC; i++)
		begin : g_prio
			assign above[i+1] = above[i] | act[i];
			assign win[i] = act[i] & ~above[i]; // RULE5
		end
	endgenerate

	always_comb
	begin
		sel = 5'h00;
		for (int k = 0; k < NSRC; k++)
		begin
			if (win[k])
			begin
				sel = 5'(k);
			end
		end
	end

	assign src.hit = above[NSRC];
	assign src.vec_code = src.hit ? (VEC_TOP - sel) : 5'h00; // RULE5

endmodule

`default_nettype wire

// ===== verification/vic_props.sv
// Purpose: Port-level checks for the interrupt controller.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every instance of the top module.
`default_nettype none
module vic_props
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register read channel
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// Core side
	input wire logic nmi_in,
	input wire logic core_intr_req,
	input wire logic intr_ack_cycle,
	input wire logic [15:0] ext_bus_vector,
	input wire logic ext_bus_vector_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence nmi_edge;
		$rose(nmi_in) ##1 !intr_ack_cycle;
	endsequence
	sequence ack_taken;
		intr_ack_cycle && core_intr_req;
	endsequence

	a_vec_after_ack: assert property (ack_taken |=> ext_bus_vector_valid)
		else $error("no vector after acknowledge");
	a_vec_needs_ack: assert property (
		ext_bus_vector_valid |-> $past(intr_ack_cycle))
		else $error("vector without acknowledge");
	a_req_drop_ack: assert property (
		ext_bus_vector_valid |-> !core_intr_req)
		else $error("request still up after acknowledge");
	a_vec_codes: assert property (ext_bus_vector_valid |->
		ext_bus_vector inside {16'h001e, 16'h001c, 16'h001a, 16'h0018})
		else $error("vector outside the source table");
	a_nmi_first: assert property (
		first_match(nmi_edge ##[1:6] ack_taken) |=>
		ext_bus_vector == 16'h001e)
		else $error("edge request not served first");
	a_req_after_reset: assert property (
		$rose(aresetn) |-> !core_intr_req)
		else $error("request up right after reset");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");
	a_rd_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
endmodule

bind vic_top vic_props u_props
(
	.aclk,
	.aresetn,
	.s_axi_arvalid,
	.s_axi_arready,
	.s_axi_rvalid,
	.nmi_in,
	.core_intr_req,
	.intr_ack_cycle,
	.ext_bus_vector,
	.ext_bus_vector_valid
);
`default_nettype wire

// ===== verification/core_model.sv
// Purpose: Behavioural core running acknowledge cycles and returns.
// Assumes: Acknowledge and return are one-cycle pulses.
// Notes: Returns only when the bench asks; slow delays acknowledges.
`default_nettype none
module core_model
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Controller side
	input wire logic core_intr_req,
	input wire logic ext_bus_vector_valid,
	input wire logic [15:0] ext_bus_vector,
	output logic intr_ack_cycle,
	output logic intr_return,
	output logic [15:0] call_addr,
	// Bench control
	input wire logic ret_go,
	input wire logic slow
);
	timeunit 1ns;
	timeprecision 1ps;
	logic in_handler_r;
	logic [1:0] wait_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			intr_ack_cycle <= 1'h0;
			intr_return <= 1'h0;
			call_addr <= 16'h0;
			in_handler_r <= 1'h0;
			wait_r <= 2'h0;
		end
		else
		begin
			wait_r <= core_intr_req ? wait_r + 2'h1 : 2'h0;
			intr_ack_cycle <= core_intr_req && !intr_ack_cycle &&
				!in_handler_r && (!slow || wait_r == 2'h3);
			intr_return <= ret_go && in_handler_r;
			if (intr_return)
				in_handler_r <= 1'h0;
			if (ext_bus_vector_valid)
			begin
				in_handler_r <= 1'h1;
				call_addr <= ext_bus_vector;
			end
		end
	end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: The core model acknowledges a request that is up, after a wait when slow is set.
// Notes: Outputs are sampled at the edge, before that edge's updates.
`default_nettype none
module testbench
	import vic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, nmi_in, ext_irq_one;
	logic pstack_underflow_irq, rstack_underflow_irq, pstack_pointer_wr;
	logic rstack_pointer_wr, core_intr_req, intr_ack_cycle, intr_return;
	logic ext_bus_vector_valid, irq, ret_go, slow;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [15:0] ext_bus_vector, call_addr;
	int errors, num_checks;

	vic_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nmi_in, .ext_irq_one,
		.pstack_underflow_irq, .rstack_underflow_irq, .pstack_pointer_wr,
		.rstack_pointer_wr, .core_intr_req, .intr_ack_cycle, .intr_return,
		.ext_bus_vector, .ext_bus_vector_valid, .irq);
	core_model u_core (.aclk, .aresetn, .core_intr_req,
		.ext_bus_vector_valid, .ext_bus_vector, .intr_ack_cycle,
		.intr_return, .call_addr, .ret_go, .slow);

	initial
	begin
		aclk = 1'h0;
		forever #4 aclk = ~aclk;
	end

	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid)
				break;
		end
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid)
				break;
		end
		rd_d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	// Waits for the next vector pulse and compares what it carries; a
	// missing pulse must fail, or a stale vector would pass unnoticed.
	task automatic vec(input logic [15:0] exp);
		for (int n = 0; n < 50 && ext_bus_vector_valid !== 1'h1; n++)
			@(posedge aclk);
		chk({31'h0, ext_bus_vector_valid}, 32'h1);
		chk({16'h0, ext_bus_vector}, {16'h0, exp});
		@(posedge aclk);
		chk({16'h0, call_addr}, {16'h0, exp});
	endtask

	task automatic ret();
		@(posedge aclk);
		ret_go <= 1'h1;
		@(posedge aclk);
		ret_go <= 1'h0;
		repeat (3) @(posedge aclk);
	endtask

	task automatic t_reset();
		rd(OFF_STATUS);
		chk(rd_d, 32'h4000);
		rd(OFF_CONFIG);
		chk(rd_d, 32'h0);
		rd(OFF_MASK);
		chk(rd_d, 32'he);
		rd(8'h40);
		chk({30'h0, resp}, 32'h2);
	endtask

	task automatic t_enable();
		ext_irq_one <= 1'h1;
		wr(OFF_MASK, 32'h0);
		chk({31'h0, core_intr_req}, 32'h0);
		rd(OFF_CONFIG);
		wr(OFF_CONFIG, rd_d);
		vec(16'h001c);
		rd(OFF_STATUS);
		chk(rd_d, 32'h4002);
		ret();
		vec(16'h001c);
		ext_irq_one <= 1'h0;
		ret();
		chk({31'h0, core_intr_req}, 32'h0);
	endtask

	// All three latched sources arrive while disabled, then drain in order.
	task automatic t_prio();
		slow <= 1'h1;
		wr(OFF_CONFIG, 32'h10);
		nmi_in <= 1'h1;
		pstack_underflow_irq <= 1'h1;
		rstack_underflow_irq <= 1'h1;
		@(posedge aclk);
		{nmi_in, pstack_underflow_irq, rstack_underflow_irq} <= 3'h0;
		repeat (3) @(posedge aclk);
		chk({31'h0, core_intr_req}, 32'h0);
		wr(OFF_CONFIG, 32'h0);
		vec(16'h001e);
		ret();
		vec(16'h001a);
		ret();
		vec(16'h001a);
		pstack_pointer_wr <= 1'h1;
		@(posedge aclk);
		pstack_pointer_wr <= 1'h0;
		ret();
		vec(16'h0018);
		rstack_pointer_wr <= 1'h1;
		@(posedge aclk);
		rstack_pointer_wr <= 1'h0;
		ret();
		chk({31'h0, core_intr_req}, 32'h0);
		slow <= 1'h0;
	endtask

	task automatic t_mask();
		wr(OFF_MASK, 32'he);
		ext_irq_one <= 1'h1;
		pstack_underflow_irq <= 1'h1;
		@(posedge aclk);
		pstack_underflow_irq <= 1'h0;
		repeat (4) @(posedge aclk);
		chk({31'h0, core_intr_req}, 32'h0);
		nmi_in <= 1'h1;
		vec(16'h001e);
		nmi_in <= 1'h0;
		ret();
		chk({31'h0, core_intr_req}, 32'h0);
		wr(OFF_MASK, 32'h0);
		vec(16'h001c);
		ext_irq_one <= 1'h0;
		ret();
		vec(16'h001a);
		pstack_pointer_wr <= 1'h1;
		@(posedge aclk);
		pstack_pointer_wr <= 1'h0;
		ret();
	endtask

	task automatic t_evt();
		wr(OFF_EVT_STAT, 32'h1f);
		chk({31'h0, irq}, 32'h0);
		wr(OFF_EVT_MASK, 32'h10);
		ext_irq_one <= 1'h1;
		vec(16'h001c);
		ext_irq_one <= 1'h0;
		chk({31'h0, irq}, 32'h1);
		rd(OFF_EVT_STAT);
		chk(rd_d, 32'h12);
		rd(OFF_VECTOR);
		chk(rd_d, 32'h1c);
		wr(OFF_EVT_MASK, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(OFF_EVT_MASK, 32'h10);
		chk({31'h0, irq}, 32'h1);
		wr(OFF_EVT_STAT, 32'h10);
		chk({31'h0, irq}, 32'h0);
		ret();
		wr(OFF_STATUS, 32'h0);
		chk({30'h0, resp}, 32'h0);
		wr(8'h3c, 32'h0);
		chk({30'h0, resp}, 32'h2);
	endtask

	initial
	begin
		#100000;
		errors++;
		conclude();
	end

	initial
	begin
		aresetn = 1'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, ret_go, slow} = 4'h0;
		{nmi_in, ext_irq_one, pstack_underflow_irq} = 3'h0;
		{rstack_underflow_irq, pstack_pointer_wr, rstack_pointer_wr} = 3'h0;
		s_axi_awaddr = 8'h0;
		s_axi_araddr = 8'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		errors = 0;
		num_checks = 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset();
		t_enable();
		t_prio();
		t_mask();
		t_evt();
		conclude();
	end
endmodule
`default_nettype wire
